// [msis_sequencer.sv]
// Motion step sequencer with AXI4-Lite registers, step insertion and mode select.
// How it works
// - Chained step starts a plain next step after completion plus its delay.
// - Insert-flagged next step counts delay from preceding step start.
// - Table holds 63 steps, each of five motion kinds.
// - Internal insertion comes from the sequence, external from a trigger input.
// - External insertion ignores delays of the preceding steps.
// - Preemptive external step discards remaining chain and runs at once.
// - Non-preemptive external step waits pending until current step completes.
// - Volatile parameters are lost at power-off; they reset to zero.
// - Restart-class parameter writes take effect only after power cycling.
// - Servo-off-class parameter writes are refused while servo is on.
// - Servo leaves on state by input low or servo-off parameter one.
// - Expansion parameters stay write-protected until permit value written.
// - Pulse, stored-step and torque modes select pulse, step, analog sources.
// - Speed mode picks analog or register speed by a discrete input.
// - Hybrid modes switch component modes by the mode-switch input.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "msis_defines.svh"
module msis_sequencer import msis_pkg::*; #(
  parameter int unsigned NSTEPS    = 63,
  parameter int unsigned MS_CYCLES = `MSIS_MS_CYCLES
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Host discrete inputs.
  input  wire logic        i_servo_on_input,
  input  wire logic        i_mode_switch_input,
  input  wire logic        i_speed_src_input,
  input  wire logic        i_step_trig,
  input  wire logic [5:0]  i_step_trig_index,
  // Motion engine handshake.
  input  wire logic        i_step_done,
  output logic             o_step_start,
  output logic [5:0]       o_step_index,
  output logic [2:0]       o_step_kind,
  output logic             o_busy,
  output logic             o_servo_on,
  output logic [2:0]       o_cmd_src,
  // AXI4-Lite slave.
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);
  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [1:0] son_s, lop_s, spd_s, trg_s;
  logic [5:0] tix_s1, tix_s2;
  logic       trg_d;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      son_s  <= 2'b00;
      lop_s  <= 2'b00;
      spd_s  <= 2'b00;
      trg_s  <= 2'b00;
      tix_s1 <= 6'h00;
      tix_s2 <= 6'h00;
      trg_d  <= 1'b0;
    end else begin
      son_s  <= {son_s[0], i_servo_on_input};
      lop_s  <= {lop_s[0], i_mode_switch_input};
      spd_s  <= {spd_s[0], i_speed_src_input};
      trg_s  <= {trg_s[0], i_step_trig};
      tix_s1 <= i_step_trig_index;
      tix_s2 <= tix_s1;
      trg_d  <= trg_s[1];
    end
  end
  logic trig_rise;
  assign trig_rise = trg_s[1] & ~trg_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [3:0]  mode;
  logic [31:0] expwr, soffp, pvol, prst_live, prst_pend, psoff, pexp;
  logic [5:0]  step_sel, cmd_step;
  logic        ctrl_start;
  msis_step_t  steps [1:63];
  logic        servo_on;
  assign servo_on = son_s[1] & (soffp != 32'h00000001);

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // Write channel: address and data taken in either order.
  logic        aw_held, w_held;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  s_q;
  logic        wr_go;
  assign aw_held = ~o_awready;
  assign w_held  = ~o_wready;
  assign wr_go   = aw_held & w_held & ~o_bvalid;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      aw_q      <= 8'h00;
      w_q       <= 32'h00000000;
      s_q       <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        aw_q      <= i_awaddr;
      end else if (wr_go) begin
        o_awready <= 1'b1;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        w_q      <= i_wdata;
        s_q      <= i_wstrb;
      end else if (wr_go) begin
        o_wready <= 1'b1;
      end
    end
  end

  logic wr_seq_start;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bvalid     <= 1'b0;
      o_bresp      <= `MSIS_RESP_OKAY;
      expwr        <= 32'h00000000;
      soffp        <= 32'h00000000;
      pvol         <= 32'h00000000;
      psoff        <= 32'h00000000;
      pexp         <= 32'h00000000;
      step_sel     <= 6'h01;
      cmd_step     <= 6'h01;
      wr_seq_start <= 1'b0;
      for (int i = 1; i <= 63; i++) steps[i] <= '0;
    end else begin
      wr_seq_start <= 1'b0;
      if (o_bvalid && i_bready) o_bvalid <= 1'b0;
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= `MSIS_RESP_OKAY;
        case (aw_q)
          // mode is restart class, stored in its own process below.
          `MSIS_ADDR_MODE, `MSIS_ADDR_PRST: begin
          end
          `MSIS_ADDR_EXPWR:   expwr <= wmask(expwr, w_q, s_q);
          `MSIS_ADDR_SOFFP:   soffp <= wmask(soffp, w_q, s_q);
          `MSIS_ADDR_PVOL:    pvol <= wmask(pvol, w_q, s_q);
          `MSIS_ADDR_PSOFF: begin
            if (servo_on) o_bresp <= `MSIS_RESP_SLVERR;
            else psoff <= wmask(psoff, w_q, s_q);
          end
          `MSIS_ADDR_PEXP: begin
            if (expwr != `MSIS_EXPWR_PERMIT) o_bresp <= `MSIS_RESP_SLVERR;
            else pexp <= wmask(pexp, w_q, s_q);
          end
          `MSIS_ADDR_STEP_SEL: begin
            if (w_q[5:0] != 6'h00) step_sel <= w_q[5:0];
          end
          `MSIS_ADDR_STEP_DATA: begin
            steps[step_sel] <= '{next:     w_q[`MSIS_STEP_NEXT_LSB +: 6],
                                 delay_ms: w_q[`MSIS_STEP_DLY_LSB +: 16],
                                 chain:    w_q[`MSIS_STEP_CHAIN],
                                 preempt:  w_q[`MSIS_STEP_PREEMPT],
                                 kind:     w_q[`MSIS_STEP_TYPE_LSB +: 3]};
          end
          `MSIS_ADDR_CMDSTEP: begin
            if (w_q[5:0] != 6'h00) cmd_step <= w_q[5:0];
          end
          `MSIS_ADDR_CTRL:    wr_seq_start <= w_q[`MSIS_CTRL_START];
          default:            o_bresp <= `MSIS_RESP_DECERR;
        endcase
      end
    end
  end
  // Restart-class values are sampled once at reset release only.
  logic boot_done;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      boot_done <= 1'b0;
    end else begin
      boot_done <= 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) mode <= `MSIS_RST_MODE;
    else if (!boot_done) mode <= prst_pend[3:0];
  end
  // restart storage.
  // It has no reset, standing in for memory kept across power loss; it is unknown until written.
  always_ff @(posedge i_clk) begin
    if (wr_go && (aw_q == `MSIS_ADDR_MODE || aw_q == `MSIS_ADDR_PRST)) begin
      prst_pend <= wmask(prst_pend, w_q, s_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_WAIT} msis_state_t;
  msis_state_t state;
  logic [5:0]  cur;
  logic        cur_done, pend_valid;
  logic [5:0]  pend_idx;
  logic [15:0] ms;
  logic        start_now;
  logic [5:0]  start_idx;
  msis_step_t  cs, ns;
  assign cs = steps[cur == 6'h00 ? 6'h01 : cur];
  assign ns = steps[cs.next == 6'h00 ? 6'h01 : cs.next];

  logic        tmr_clear;
  // a plain chain counts its delay from completion, an insert from the start.
  assign tmr_clear = start_now | (state == S_RUN && i_step_done && !ns.preempt);

  msis_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_timer (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_clear(tmr_clear),
    .o_ms   (ms)
  );

  always_comb begin
    start_now = 1'b0;
    start_idx = cur;
    if (!servo_on) begin
      start_now = 1'b0;
    end else if (trig_rise && tix_s2 != 6'h00 && steps[tix_s2].preempt) begin
      start_now = 1'b1;
      start_idx = tix_s2;
    end else if (pend_valid && (state == S_IDLE || (state != S_IDLE && cur_done))) begin
      start_now = 1'b1;
      start_idx = pend_idx;
    end else if (state == S_IDLE && wr_seq_start) begin
      start_now = 1'b1;
      start_idx = cmd_step;
    end else if (state != S_IDLE && cs.chain && cs.next != 6'h00) begin
      if (ns.preempt && ms >= cs.delay_ms) begin
        start_now = 1'b1;
        start_idx = cs.next;
      end else if (!ns.preempt && state == S_WAIT && ms >= cs.delay_ms) begin
        start_now = 1'b1;
        start_idx = cs.next;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_valid <= 1'b0;
      pend_idx   <= 6'h00;
    end else if (!servo_on) begin
      pend_valid <= 1'b0;
    end else if (trig_rise && tix_s2 != 6'h00 && !steps[tix_s2].preempt) begin
      pend_valid <= 1'b1;
      pend_idx   <= tix_s2;
    end else if (start_now && start_idx == pend_idx) begin
      pend_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state        <= S_IDLE;
      cur          <= 6'h00;
      cur_done     <= 1'b0;
      o_step_start <= 1'b0;
      o_step_index <= 6'h00;
      o_step_kind  <= 3'h0;
      o_busy       <= 1'b0;
    end else begin
      o_step_start <= 1'b0;
      if (!servo_on) begin
        state  <= S_IDLE;
        o_busy <= 1'b0;
      end else if (start_now) begin
        state        <= S_RUN;
        cur          <= start_idx;
        cur_done     <= 1'b0;
        o_step_start <= 1'b1;
        o_step_index <= start_idx;
        o_step_kind  <= steps[start_idx].kind;
        o_busy       <= 1'b1;
      end else if (state == S_RUN && i_step_done) begin
        cur_done <= 1'b1;
        // A plain chain waits in S_WAIT for its delay, counted from this completion.
        if (cs.chain && !ns.preempt) state <= S_WAIT;
        else if (!cs.chain) begin
          state  <= S_IDLE;
          o_busy <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode and command source.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_cmd_src  <= MSIS_SRC_NONE;
      o_servo_on <= 1'b0;
    end else begin
      o_servo_on <= servo_on;
      case (msis_mode_t'(mode))
        MSIS_M_PT:   o_cmd_src <= MSIS_SRC_PULSE;
        MSIS_M_PR:   o_cmd_src <= MSIS_SRC_STEP;
        MSIS_M_S:    o_cmd_src <= spd_s[1] ? MSIS_SRC_REG_SPD : MSIS_SRC_ANA_SPD;
        MSIS_M_T:    o_cmd_src <= MSIS_SRC_ANA_TRQ;
        MSIS_M_PT_S: o_cmd_src <= lop_s[1] ? (spd_s[1] ? MSIS_SRC_REG_SPD : MSIS_SRC_ANA_SPD)
                                           : MSIS_SRC_PULSE;
        MSIS_M_PT_T: o_cmd_src <= lop_s[1] ? MSIS_SRC_ANA_TRQ : MSIS_SRC_PULSE;
        MSIS_M_PR_S: o_cmd_src <= lop_s[1] ? (spd_s[1] ? MSIS_SRC_REG_SPD : MSIS_SRC_ANA_SPD)
                                           : MSIS_SRC_STEP;
        MSIS_M_PR_T: o_cmd_src <= lop_s[1] ? MSIS_SRC_ANA_TRQ : MSIS_SRC_STEP;
        MSIS_M_S_T:  o_cmd_src <= lop_s[1] ? MSIS_SRC_ANA_TRQ
                                           : (spd_s[1] ? MSIS_SRC_REG_SPD : MSIS_SRC_ANA_SPD);
        default:     o_cmd_src <= MSIS_SRC_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel.
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h00000000;
    case (i_araddr)
      `MSIS_ADDR_STATUS:   rd_val = {24'h000000, pend_valid, cur_done, o_busy, servo_on,
                                     2'b00, 2'(state)};
      `MSIS_ADDR_MODE:     rd_val = {28'h0000000, mode};
      `MSIS_ADDR_EXPWR:    rd_val = expwr;
      `MSIS_ADDR_SOFFP:    rd_val = soffp;
      `MSIS_ADDR_PVOL:     rd_val = pvol;
      `MSIS_ADDR_PRST:     rd_val = prst_live;
      `MSIS_ADDR_PSOFF:    rd_val = psoff;
      `MSIS_ADDR_PEXP:     rd_val = pexp;
      `MSIS_ADDR_STEP_SEL: rd_val = {26'h0000000, step_sel};
      `MSIS_ADDR_CMDSTEP:  rd_val = {26'h0000000, cmd_step};
      `MSIS_ADDR_ACTIVE:   rd_val = {10'h000, ms, cur};
      default:             rd_val = 32'h00000000;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
      o_rdata   <= 32'h00000000;
      o_rresp   <= `MSIS_RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid  <= 1'b1;
      o_arready <= 1'b0;
      o_rdata  <= rd_val;
      o_rresp  <= (i_araddr <= `MSIS_ADDR_ACTIVE && i_araddr[1:0] == 2'b00 &&
                   i_araddr != `MSIS_ADDR_CTRL && i_araddr != `MSIS_ADDR_STEP_DATA)
                  ? `MSIS_RESP_OKAY : `MSIS_RESP_DECERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end
  // Restart-class readback shows the live value latched at boot.
  assign prst_live = {28'h0000000, mode};
endmodule // msis_sequencer
`default_nettype wire

// [msis_defines.svh]
// Offsets, field positions, reset values and timing counts of the step sequencer.
`ifndef MSIS_DEFINES_SVH
`define MSIS_DEFINES_SVH
`define MSIS_CLK_HZ          25000000
`define MSIS_MS_CYCLES       ((`MSIS_CLK_HZ + 999) / 1000)
`define MSIS_ADDR_CTRL       8'h00
`define MSIS_ADDR_STATUS     8'h04
`define MSIS_ADDR_MODE       8'h08
`define MSIS_ADDR_EXPWR      8'h0C
`define MSIS_ADDR_SOFFP      8'h10
`define MSIS_ADDR_PVOL       8'h14
`define MSIS_ADDR_PRST       8'h18
`define MSIS_ADDR_PSOFF      8'h1C
`define MSIS_ADDR_PEXP       8'h20
`define MSIS_ADDR_STEP_SEL   8'h24
`define MSIS_ADDR_STEP_DATA  8'h28
`define MSIS_ADDR_CMDSTEP    8'h2C
`define MSIS_ADDR_ACTIVE     8'h30
`define MSIS_CTRL_START      0
`define MSIS_CTRL_DONE       1
`define MSIS_STEP_TYPE_LSB   0
`define MSIS_STEP_CHAIN      4
`define MSIS_STEP_PREEMPT    5
`define MSIS_STEP_NEXT_LSB   8
`define MSIS_STEP_DLY_LSB    16
`define MSIS_EXPWR_PERMIT    32'h00000001
`define MSIS_RST_MODE        4'h0
`define MSIS_RESP_OKAY       2'b00
`define MSIS_RESP_SLVERR     2'b10
`define MSIS_RESP_DECERR     2'b11
`endif

// [msis_pkg.sv]
// Types shared by the step sequencer files.
package msis_pkg;
  typedef enum logic [2:0] {
    MSIS_T_SPEED, MSIS_T_POS, MSIS_T_JUMP, MSIS_T_PWRITE, MSIS_T_INDEX
  } msis_type_t;
  typedef enum logic [3:0] {
    MSIS_M_PT, MSIS_M_PR, MSIS_M_S, MSIS_M_T,
    MSIS_M_PT_S, MSIS_M_PT_T, MSIS_M_PR_S, MSIS_M_PR_T, MSIS_M_S_T
  } msis_mode_t;
  typedef enum logic [2:0] {
    MSIS_SRC_NONE, MSIS_SRC_PULSE, MSIS_SRC_STEP, MSIS_SRC_ANA_SPD,
    MSIS_SRC_REG_SPD, MSIS_SRC_ANA_TRQ
  } msis_src_t;
  typedef struct packed {
    logic [5:0]  next;
    logic [15:0] delay_ms;
    logic        chain;
    logic        preempt;
    logic [2:0]  kind;
  } msis_step_t;
  typedef struct packed {
    logic        valid;
    logic [5:0]  index;
  } msis_trig_t;
endpackage : msis_pkg

// [msis_ms_timer.sv]
// Millisecond tick divider and elapsed-millisecond counter.
`timescale 1ns/1ps
`default_nettype none
`include "msis_defines.svh"
module msis_ms_timer import msis_pkg::*; #(
  parameter int unsigned MS_CYCLES = `MSIS_MS_CYCLES
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Control and count.
  input  wire logic        i_clear,
  output logic [15:0]      o_ms
);
  logic [15:0] div;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div  <= 16'h0000;
      o_ms <= 16'h0000;
    end else if (i_clear) begin
      div  <= 16'h0000;
      o_ms <= 16'h0000;
    end else if (div == 16'(MS_CYCLES - 1)) begin
      div <= 16'h0000;
      // Saturate so a long idle never wraps into a short delay.
      if (o_ms != 16'hFFFF) begin
        o_ms <= o_ms + 16'h0001;
      end
    end else begin
      div <= div + 16'h0001;
    end
  end
endmodule // msis_ms_timer
`default_nettype wire

// [msis_checker.sv]
// Concurrent checks on the step sequencer top-level ports.
`timescale 1ns/1ps
`default_nettype none
module msis_checker (
  // Clock and reset.
  input wire logic       i_clk,
  input wire logic       i_rstn,
  // Host and engine side.
  input wire logic       i_servo_on_input,
  input wire logic       o_step_start,
  input wire logic [5:0] o_step_index,
  input wire logic [2:0] o_step_kind,
  input wire logic       o_busy,
  input wire logic       o_servo_on,
  // Register bus.
  input wire logic       i_awvalid,
  input wire logic       o_awready,
  input wire logic       i_wvalid,
  input wire logic       o_wready,
  input wire logic       o_bvalid,
  input wire logic       i_bready,
  input wire logic       i_arvalid,
  input wire logic       o_arready,
  input wire logic       o_rvalid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  chk_start_pulse: assert property (o_step_start |=> !o_step_start)
    else $error("step start wider than one cycle");
  chk_start_busy: assert property (o_step_start |-> o_busy)
    else $error("step started while not busy");
  chk_step_range: assert property (o_step_start |->
    (o_step_index inside {[1:63]}) && (o_step_kind <= 3'h4))
    else $error("step index or kind out of range");
  chk_servo_drop: assert property ($fell(i_servo_on_input) |-> ##[1:5] !o_servo_on)
    else $error("servo stayed on after input fell");
  chk_abort_seq: assert property ($fell(o_servo_on) |-> ##[0:3] !o_busy)
    else $error("sequence kept running with servo off");
  chk_read_ans: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  chk_read_block: assert property (o_rvalid |-> !o_arready)
    else $error("read address accepted during answer");
  chk_write_ans: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |-> ##[1:2] o_bvalid)
    else $error("write answer late");
  chk_bvalid_once: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write answer repeated");
endmodule // msis_checker

bind msis_sequencer msis_checker u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_servo_on_input(i_servo_on_input),
  .o_step_start(o_step_start), .o_step_index(o_step_index), .o_step_kind(o_step_kind),
  .o_busy(o_busy), .o_servo_on(o_servo_on), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid));
`default_nettype wire

// [msis_engine_model.sv]
// Behavioural motion engine that reports step completion.
`timescale 1ns/1ps
`default_nettype none
module msis_engine_model (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // Step handshake.
  input  wire logic       i_start,
  input  wire logic [7:0] i_lat,
  output logic            o_done
);
  logic [7:0] cnt;

  // A latency of zero never completes, which models a stuck long move.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt    <= 8'h00;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt == 8'h01);
      if (i_start) cnt <= i_lat;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    end
  end
endmodule // msis_engine_model
`default_nettype wire

// [test_motion_step_insert_sequencer.sv]
// Self-checking testbench for the motion step sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "msis_defines.svh"
module test_motion_step_insert_sequencer;
  import msis_pkg::*;
  logic        clk, rstn, servo_on_input, trig, done, start, busy, servo, mode_switch_input, spd;
  logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [5:0]  tidx, sidx;
  logic [2:0]  kind, src;
  logic [7:0]  awaddr, araddr, lat;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          fail_count, n_checks;

  msis_sequencer #(.MS_CYCLES(10)) u_dut (
    .i_clk(clk), .i_rstn(rstn), .i_servo_on_input(servo_on_input), .i_mode_switch_input(mode_switch_input),
    .i_speed_src_input(spd), .i_step_trig(trig), .i_step_trig_index(tidx),
    .i_step_done(done), .o_step_start(start), .o_step_index(sidx), .o_step_kind(kind),
    .o_busy(busy), .o_servo_on(servo), .o_cmd_src(src), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'b1));
  msis_engine_model u_eng (.i_clk(clk), .i_rstn(rstn), .i_start(start), .i_lat(lat),
    .o_done(done));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   t;
    logic aw_ok, w_ok, b_ok;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    b_ok    = 1'b0;
    r       = 2'b00;
    for (t = 0; t < 50 && !b_ok; t++) begin
      // Handshakes are judged on settled values, just before the edge that takes them.
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok  = wvalid && wready;
      b_ok  = bvalid;
      r     = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    if (!b_ok) fail_count++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   t;
    logic ar_ok, r_ok;
    araddr  <= a;
    arvalid <= 1'b1;
    r_ok    = 1'b0;
    d       = 32'h00000000;
    r       = 2'b00;
    for (t = 0; t < 50 && !r_ok; t++) begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      r_ok  = rvalid;
      d     = rdata;
      r     = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end
    if (!r_ok) fail_count++;
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic prog(input logic [5:0] n, input logic [31:0] d);
    logic [1:0] r;
    wr(`MSIS_ADDR_STEP_SEL, {26'h0, n}, r);
    wr(`MSIS_ADDR_STEP_DATA, d, r);
  endtask

  task automatic run(input logic [5:0] n);
    logic [1:0] r;
    wr(`MSIS_ADDR_CMDSTEP, {26'h0, n}, r);
    wr(`MSIS_ADDR_CTRL, 32'h00000001, r);
  endtask

  // Waits for the next step start and counts the cycles it took.
  task automatic nxt(input logic [5:0] n, input logic [2:0] k, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (!start && c < 2000);
    if (c == 2000) fail_count++;
    chk("step_index", {26'h0, n}, {26'h0, sidx});
    chk("step_kind", {29'h0, k}, {29'h0, kind});
    @(posedge clk);
  endtask

  // The index is set one edge ahead so it is stable when the trigger rises.
  task automatic trg(input logic [5:0] n);
    tidx <= n;
    @(posedge clk);
    trig <= 1'b1;
  endtask

  task automatic t_regs();
    logic [1:0]  r;
    logic [31:0] d;
    wr(`MSIS_ADDR_PSOFF, 32'h00000001, r);
    chk("psoff_resp", {30'h0, `MSIS_RESP_SLVERR}, {30'h0, r});
    wr(`MSIS_ADDR_PEXP, 32'h00000001, r);
    chk("pexp_locked", {30'h0, `MSIS_RESP_SLVERR}, {30'h0, r});
    wr(`MSIS_ADDR_EXPWR, `MSIS_EXPWR_PERMIT, r);
    wr(`MSIS_ADDR_PEXP, 32'h00000001, r);
    rd(`MSIS_ADDR_PEXP, d, r);
    chk("pexp_open", 32'h00000001, d);
    rd(8'h40, d, r);
    chk("unmapped", {30'h0, `MSIS_RESP_DECERR}, {30'h0, r});
    wr(`MSIS_ADDR_PVOL, 32'h0000A5A5, r);
    wr(`MSIS_ADDR_MODE, 32'h00000000, r);
    do_reset();
    rd(`MSIS_ADDR_PVOL, d, r);
    chk("pvol_lost", 32'h00000000, d);
    chk("cmd_src", {29'h0, MSIS_SRC_PULSE}, {29'h0, src});
    wr(`MSIS_ADDR_MODE, {28'h0, MSIS_M_PR_S}, r);
    repeat (4) @(posedge clk);
    chk("mode_held", {29'h0, MSIS_SRC_PULSE}, {29'h0, src});
    do_reset();
    chk("mode_boot", {29'h0, MSIS_SRC_STEP}, {29'h0, src});
    mode_switch_input <= 1'b1;
    spd <= 1'b1;
    repeat (4) @(posedge clk);
    chk("hyb_reg_spd", {29'h0, MSIS_SRC_REG_SPD}, {29'h0, src});
    spd <= 1'b0;
    repeat (4) @(posedge clk);
    chk("hyb_ana_spd", {29'h0, MSIS_SRC_ANA_SPD}, {29'h0, src});
    mode_switch_input <= 1'b0;
  endtask

  task automatic t_chain();
    int c;
    lat <= 8'h05;
    prog(6'd1, 32'h00020211);
    prog(6'd2, 32'h00000002);
    run(6'd1);
    nxt(6'd1, 3'h1, c);
    nxt(6'd2, 3'h2, c);
    chk("chain_delay", 32'h1, {31'h0, c >= 25});
  endtask

  task automatic t_internal();
    int c;
    lat <= 8'h3C;
    // Insert delay shorter than the move, so the move is cut short.
    prog(6'd7, 32'h00010811);
    prog(6'd8, 32'h00000024);
    run(6'd7);
    nxt(6'd7, 3'h1, c);
    nxt(6'd8, 3'h4, c);
    chk("insert_time", 32'h1, {31'h0, c >= 10 && c <= 30});
    repeat (60) @(posedge clk);
  endtask

  task automatic t_extern();
    int c;
    lat <= 8'h00;
    prog(6'd5, 32'h00320611);
    prog(6'd3, 32'h00000020);
    prog(6'd4, 32'h00000004);
    run(6'd5);
    nxt(6'd5, 3'h1, c);
    lat <= 8'h28;
    trg(6'd3);
    nxt(6'd3, 3'h0, c);
    chk("preempt_time", 32'h1, {31'h0, c <= 12});
    repeat (6) @(posedge clk);
    trig <= 1'b0;
    trg(6'd4);
    nxt(6'd4, 3'h4, c);
    chk("pend_wait", 32'h1, {31'h0, c >= 25});
    trig <= 1'b0;
    repeat (60) @(posedge clk);
  endtask

  task automatic t_servo();
    logic [1:0] r;
    wr(`MSIS_ADDR_SOFFP, 32'h00000001, r);
    repeat (4) @(posedge clk);
    chk("soff_param", 32'h0, {31'h0, servo});
    wr(`MSIS_ADDR_SOFFP, 32'h00000000, r);
    repeat (6) @(posedge clk);
    chk("soff_restore", 32'h1, {31'h0, servo});
    servo_on_input <= 1'b0;
    repeat (6) @(posedge clk);
    chk("son_low", 32'h0, {31'h0, servo});
    wr(`MSIS_ADDR_PSOFF, 32'h00000001, r);
    chk("psoff_ok", {30'h0, `MSIS_RESP_OKAY}, {30'h0, r});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    {rstn, trig, awvalid, wvalid, arvalid, mode_switch_input, spd} = 7'h00;
    servo_on_input = 1'b1;
    tidx = 6'h00;
    lat = 8'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    do_reset();
    t_regs();
    t_chain();
    t_internal();
    t_extern();
    t_servo();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule // test_motion_step_insert_sequencer
`default_nettype wire
